// file: rtl/ext_bus_pkg.sv
package ext_bus_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int LANES = 4;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam int LANE_M1 = 3;
  localparam int LANE_M2 = 2;
  localparam logic [3:0] LANES_OFF = 4'hf;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic [1:0] HALF_FIRST = 2'h0;
  localparam logic [1:0] HALF_SECOND = 2'h1;
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCESS = 3'h1,
    ST_WAIT_RDY = 3'h3,
    ST_DONE = 3'h2,
    ST_RELEASED = 3'h4
  } bus_state_t;
endpackage

// file: rtl/lane_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lane_if;
  import ext_bus_pkg::*;
  logic [1:0] mem_width;
  logic [1:0] addr_low;
  logic [3:0] lane_mask;
  logic active;
  logic [3:0] pins;
  modport core (output mem_width, output addr_low, output lane_mask,
    output active, input pins);
  modport mapper (input mem_width, input addr_low, input lane_mask,
    input active, output pins);
endinterface
`default_nettype wire

// file: rtl/lane_mapper.sv
`timescale 1ns/100ps
`default_nettype none
module lane_mapper
  import ext_bus_pkg::*;
(
  lane_if.mapper lm
);
  // -----------------------------------------------
  // lane pin decode, active low enables
  // -----------------------------------------------
  always_comb begin
    lm.pins = LANES_OFF;
    if (lm.active) begin
      lm.pins[1:0] = ~lm.lane_mask[1:0]; // R8
      lm.pins[LANE_M2] = ~lm.lane_mask[2]; // R15
      lm.pins[LANE_M1] = ~lm.lane_mask[3];
    end
    // address lane 3 runs for every access width below 32, lane 2 only at 8-bit
    if (lm.mem_width != WIDTH_32) begin
      lm.pins[LANE_M1] = lm.addr_low[1]; // R5
    end
    if (lm.mem_width == WIDTH_8) begin
      lm.pins[LANE_M2] = lm.addr_low[0]; // R6
    end
  end
endmodule
`default_nettype wire

// file: rtl/ext_bus_pins.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - data is 32 bits both ways: driven on writes, sampled on reads
// R2 - address is 24-bit output only, may float
// R3 - read/write line high for reads, low for writes
// R4 - separate peripheral strobe for peripheral space accesses
// R5 - bank0 lane 3 is enable 3 at 32-bit, else address bit minus one
// R6 - bank0 lane 2 is enable 2 at 32-bit, address minus two at 8-bit
// R7 - bank1 lanes 3 and 2 reused exactly as bank0
// R8 - lanes 1 and 0 are always byte enables
// R9 - transaction ends only after ready is seen low
// R10 - low release request: finish, float bus, hold off until high
// R11 - release inhibit bit set: release request ignored
// R12 - float rules for float-all, release and reset per line group
// R13 - release ack low once floated, high on request high or inhibit
// R14 - program width low: one 32-bit fetch; high: two 16-bit fetches
// R15 - only enables of lanes actually moved are asserted
module ext_bus_pins
  import ext_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_io_i,
  input wire logic req_bank_i,
  input wire logic req_fetch_i,
  input wire logic [ADDR_W+1:0] req_addr_i,
  input wire logic [3:0] req_lanes_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] bank0_width_i,
  input wire logic [1:0] bank1_width_i,
  input wire logic release_inhibit_bit_i,
  input wire logic float_all_mode_i,
  input wire logic program_width_select_i,
  input wire logic ready_n_i,
  input wire logic bus_release_req_n_i,
  input wire logic [DATA_W-1:0] bus_data_lines_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  output logic [DATA_W-1:0] bus_data_lines_o,
  output logic bus_data_lines_oe_o,
  output logic [ADDR_W-1:0] bus_address_lines_o,
  output logic bus_address_lines_oe_o,
  output logic read_write_o,
  output logic read_write_oe_o,
  output logic peripheral_io_strobe_n_o,
  output logic [3:0] bank0_lanes_o,
  output logic [3:0] bank1_lanes_o,
  output logic strobes_oe_o,
  output logic bus_release_ack_n_o
);
  // -----------------------------------------------
  // pin synchronisers
  // -----------------------------------------------
  logic [1:0] rdy_s, hold_s, program_width_select_s;
  logic [DATA_W-1:0] din_s1, din_s2;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_s <= 2'h3;
      hold_s <= 2'h3;
      program_width_select_s <= 2'h0;
      din_s1 <= DATA_RESET;
      din_s2 <= DATA_RESET;
    end else begin
      rdy_s <= {rdy_s[0], ready_n_i};
      hold_s <= {hold_s[0], bus_release_req_n_i};
      program_width_select_s <= {program_width_select_s[0], program_width_select_i};
      din_s1 <= bus_data_lines_i;
      din_s2 <= din_s1; // R1
    end
  end
  wire logic rdy_ok = ~rdy_s[1];
  wire logic rel_req = ~hold_s[1] & ~release_inhibit_bit_i; // R11
  wire logic split = req_fetch_i & program_width_select_s[1]; // R14

  // -----------------------------------------------
  // bus sequencer
  // -----------------------------------------------
  bus_state_t state, next_state;
  logic [ADDR_W+1:0] addr, next_addr;
  logic [3:0] lanes, next_lanes;
  logic wr, next_wr, io, next_io, bank, next_bank, two, next_two;
  logic [1:0] half, next_half;
  logic [1:0] settle, next_settle;
  logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
  logic ack_n, next_ack_n, rv, next_rv;
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_lanes = lanes;
    next_wr = wr;
    next_io = io;
    next_bank = bank;
    next_two = two;
    next_half = half;
    next_settle = settle;
    next_wdata = wdata;
    next_rdata = rdata;
    next_ack_n = ack_n;
    next_rv = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (rel_req) begin
          next_state = ST_RELEASED; // R10
        end else if (req_valid_i) begin
          next_state = ST_ACCESS;
          next_addr = req_addr_i;
          next_lanes = req_lanes_i; // R15
          next_wr = req_write_i; // R3
          next_io = req_io_i; // R4
          next_bank = req_bank_i;
          next_two = split;
          next_half = HALF_FIRST;
          next_wdata = req_wdata_i;
        end
      end
      ST_ACCESS: begin
        next_settle = 2'h0;
        next_state = ST_WAIT_RDY;
      end
      ST_WAIT_RDY: begin
        // synced ready and data lag the pins: early samples are stale
        if (settle != SETTLE_CYCLES) begin
          next_settle = settle + 2'h1;
        end else if (rdy_ok) begin // R9
          if (!wr) begin
            if (two && half == HALF_SECOND) begin
              next_rdata = {din_s2[15:0], rdata[15:0]};
            end else begin
              next_rdata = din_s2;
            end
          end
          if (two && half == HALF_FIRST) begin
            next_half = HALF_SECOND; // R14
            // byte address, so the next halfword is two bytes on
            next_addr = addr + 26'h2;
            next_wdata = {16'h0000, wdata[31:16]};
            next_state = ST_ACCESS;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_rv = 1'b1;
        next_state = ST_IDLE;
      end
      ST_RELEASED: begin
        next_ack_n = 1'b0; // R13
        if (!rel_req) begin
          next_ack_n = 1'b1; // R13
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      addr <= 26'h0000000;
      lanes <= 4'h0;
      wr <= 1'b0;
      io <= 1'b0;
      bank <= 1'b0;
      two <= 1'b0;
      half <= HALF_FIRST;
      settle <= 2'h0;
      wdata <= DATA_RESET;
      rdata <= DATA_RESET;
      ack_n <= 1'b1;
      rv <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      lanes <= next_lanes;
      wr <= next_wr;
      io <= next_io;
      bank <= next_bank;
      two <= next_two;
      half <= next_half;
      settle <= next_settle;
      wdata <= next_wdata;
      rdata <= next_rdata;
      ack_n <= next_ack_n;
      rv <= next_rv;
    end
  end

  // -----------------------------------------------
  // lane mapping, one mapper per bank
  // -----------------------------------------------
  lane_if b0 ();
  lane_if b1 ();
  wire logic busy = (state == ST_ACCESS) || (state == ST_WAIT_RDY);
  // address low bits follow every access, strobes only the selected bank
  assign b0.mem_width = bank0_width_i;
  assign b0.addr_low = addr[1:0]; // R5
  assign b0.lane_mask = lanes;
  assign b0.active = busy & ~io & ~bank;
  assign b1.mem_width = bank1_width_i;
  assign b1.addr_low = addr[1:0]; // R7
  assign b1.lane_mask = lanes;
  assign b1.active = busy & ~io & bank;
  lane_mapper u_map0 (.lm(b0));
  lane_mapper u_map1 (.lm(b1));

  // -----------------------------------------------
  // registered pins and float control
  // -----------------------------------------------
  wire logic released = (state == ST_RELEASED);
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_data_lines_o <= DATA_RESET;
      bus_data_lines_oe_o <= 1'b0; // R12
      bus_address_lines_o <= ADDR_RESET;
      bus_address_lines_oe_o <= 1'b0;
      read_write_o <= 1'b1;
      read_write_oe_o <= 1'b0;
      peripheral_io_strobe_n_o <= 1'b1;
      bank0_lanes_o <= LANES_OFF;
      bank1_lanes_o <= LANES_OFF;
      strobes_oe_o <= 1'b1; // R12
      req_ready_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_rdata_o <= DATA_RESET;
      bus_release_ack_n_o <= 1'b1;
    end else begin
      bus_data_lines_o <= wdata; // R1
      bus_data_lines_oe_o <= busy & wr & ~float_all_mode_i & ~released;
      bus_address_lines_o <= addr[ADDR_W+1:2]; // R2
      bus_address_lines_oe_o <= ~float_all_mode_i & ~released; // R12
      read_write_o <= ~(busy & wr); // R3
      read_write_oe_o <= ~released; // R12
      peripheral_io_strobe_n_o <= ~(busy & io); // R4
      bank0_lanes_o <= b0.pins;
      bank1_lanes_o <= b1.pins;
      strobes_oe_o <= ~float_all_mode_i & ~released; // R12
      req_ready_o <= (next_state == ST_IDLE) & ~rel_req; // R10
      resp_valid_o <= rv;
      resp_rdata_o <= rdata;
      bus_release_ack_n_o <= ack_n; // R13
    end
  end

  // -----------------------------------------------
  // checks
  // -----------------------------------------------
  a_ack_floats: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !bus_release_ack_n_o |-> !bus_address_lines_oe_o && !strobes_oe_o)
    else $error("ack low with bus driven"); // R13
  a_ready_gates_end: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state == ST_WAIT_RDY && !rdy_ok |=> state == ST_WAIT_RDY)
    else $error("transaction ended without ready"); // R9
  a_release_float: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    released |=> !read_write_oe_o && !bus_data_lines_oe_o)
    else $error("bus driven while released"); // R12
  a_inhibit_ack: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    release_inhibit_bit_i && state == ST_IDLE |=> state != ST_RELEASED)
    else $error("release taken while inhibited"); // R11
  a_rw_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    busy && wr |=> !read_write_o)
    else $error("write without low read/write"); // R3
  a_io_strobe: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    busy && io |=> !peripheral_io_strobe_n_o && bank0_lanes_o[1:0] == 2'h3)
    else $error("peripheral strobe wrong"); // R4
  a_low_lanes: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !busy |=> bank0_lanes_o[1:0] == 2'h3 && bank1_lanes_o[1:0] == 2'h3)
    else $error("lane enable outside access"); // R8
  a_split_fetch: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    state == ST_WAIT_RDY && rdy_ok && settle == SETTLE_CYCLES && two &&
    half == HALF_FIRST
    |=> state == ST_ACCESS ##1 state == ST_WAIT_RDY)
    else $error("second half fetch missing"); // R14
endmodule
`default_nettype wire

// file: verif/sram_partner.sv
`timescale 1ns/100ps
`default_nettype none
module sram_partner (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sel_i,
  input wire logic rd_i,
  input wire logic [3:0] idx_i,
  input wire logic [31:0] bus_i,
  input wire logic [7:0] wait_i,
  output logic ready_n_o,
  output logic [31:0] drive_o
);
  logic [31:0] mem [16];
  logic [7:0] cnt;
  logic [31:0] last;
  // ready only after the chosen wait, held while selected
  assign ready_n_o = !(sel_i && cnt >= wait_i);
  // released data toggles so a stale value never looks valid
  assign drive_o = (sel_i && rd_i) ? mem[idx_i] : ~last;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 8'h00;
      last <= 32'h00000000;
    end else begin
      last <= drive_o;
      cnt <= sel_i ? cnt + 8'h01 : 8'h00;
      if (sel_i && !rd_i && !ready_n_o) begin
        mem[idx_i] <= bus_i;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ext_bus_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr = 1'b0, io = 1'b0;
  logic bk = 1'b0, inh = 1'b0, fam = 1'b0, rel_n = 1'b1;
  logic fch = 1'b0, pw = 1'b0;
  logic [25:0] adr = 26'h0;
  logic [3:0] lns = 4'h0;
  logic [31:0] wd = 32'h0, din, dout, rdata, drv;
  logic [1:0] w0 = WIDTH_32, w1 = WIDTH_32;
  logic rdy_n, rreq, rv, doe, aoe, rw, rwoe, ios_n, soe, ack_n, sel;
  logic [23:0] ao;
  logic [3:0] b0, b1;
  logic [7:0] wt = 8'h02;
  int err_total = 0, samples_checked = 0, cyc = 0, took;
  logic [31:0] c_addr, c_b0, c_b1, c_io, c_rw, c_doe, c_lst;
  always #20 clk = ~clk;
  assign sel = soe && (!ios_n || !b0[0] || !b1[0]);
  assign din = doe ? dout : drv;
  ext_bus_pins ext_bus_pins_inst (.ref_clk_i(clk), .reset_n_i(rst_n),
    .req_valid_i(vld), .req_write_i(wr), .req_io_i(io), .req_bank_i(bk),
    .req_fetch_i(fch), .req_addr_i(adr), .req_lanes_i(lns),
    .req_wdata_i(wd), .bank0_width_i(w0), .bank1_width_i(w1),
    .release_inhibit_bit_i(inh), .float_all_mode_i(fam),
    .program_width_select_i(pw), .ready_n_i(rdy_n),
    .bus_release_req_n_i(rel_n), .bus_data_lines_i(din),
    .req_ready_o(rreq), .resp_valid_o(rv), .resp_rdata_o(rdata),
    .bus_data_lines_o(dout), .bus_data_lines_oe_o(doe),
    .bus_address_lines_o(ao), .bus_address_lines_oe_o(aoe),
    .read_write_o(rw), .read_write_oe_o(rwoe),
    .peripheral_io_strobe_n_o(ios_n), .bank0_lanes_o(b0),
    .bank1_lanes_o(b1), .strobes_oe_o(soe), .bus_release_ack_n_o(ack_n));
  sram_partner sram_partner_inst (.clk_i(clk), .reset_n_i(rst_n),
    .sel_i(sel), .rd_i(rw), .idx_i({ao[2:0], b0[3]}), .bus_i(din),
    .wait_i(wt),
    .ready_n_o(rdy_n), .drive_o(drv));
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, i, b, input logic [25:0] a,
      input logic [3:0] l, input logic [31:0] d);
    bit got;
    got = 0;
    for (int n = 0; n < 50 && rreq !== 1'b1; n++) @(posedge clk) #1;
    {wr, io, bk, adr, lns, wd, vld} = {w, i, b, a, l, d, 1'b1};
    @(posedge clk) #1;
    vld = 1'b0;
    took = 0;
    for (int n = 0; n < 80 && rv !== 1'b1; n++) begin
      @(posedge clk) #1;
      took++;
      if (sel && !got) begin
        got = 1;
        {c_addr, c_b0, c_b1} = {8'h0, ao, 28'h0, b0, 28'h0, b1};
        {c_io, c_rw, c_doe} = {31'h0, ios_n, 31'h0, rw, 31'h0, doe};
      end
      if (sel) c_lst = {28'h0, b0};
    end
    chk("resp_valid", 32'h1, {31'h0, rv});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("rst oe", 32'h1, {28'h0, doe, aoe, rwoe, soe});
    chk("rst ack", 32'h1, {31'h0, ack_n});
    $display("test reset done");
  endtask
  task automatic t_wr_rd;
    acc(1, 0, 0, 26'h000010, 4'hf, 32'hcafe1234);
    chk("addr", 32'h4, c_addr);
    chk("rw wr", 32'h0, c_rw);
    chk("doe wr", 32'h1, c_doe);
    chk("b0 all", 32'h0, c_b0);
    acc(0, 0, 0, 26'h000010, 4'hf, 32'h0);
    chk("rw rd", 32'h1, c_rw);
    chk("rdata", 32'hcafe1234, rdata);
    $display("test write read done");
  endtask
  task automatic t_lanes;
    acc(1, 0, 0, 26'h000020, 4'h1, 32'h11);
    chk("b0 one lane", 32'he, c_b0);
    w0 = WIDTH_8;
    w1 = WIDTH_8;
    acc(1, 0, 0, 26'h000001, 4'h1, 32'h22);
    chk("b0 narrow", 32'h6, c_b0);
    acc(1, 0, 1, 26'h000022, 4'h1, 32'h33);
    chk("b1 narrow", 32'ha, c_b1);
    w0 = WIDTH_32;
    w1 = WIDTH_32;
    $display("test lanes done");
  endtask
  task automatic t_io_wait;
    wt = 8'h14;
    acc(1, 1, 0, 26'h000040, 4'hf, 32'h44);
    chk("io strobe", 32'h0, c_io);
    chk("io no b0", 32'h3, {30'h0, c_b0[1:0]});
    chk("held", 32'h1, {31'h0, took > 20});
    wt = 8'h02;
    $display("test io wait done");
  endtask
  task automatic t_release;
    fam = 1'b1;
    repeat (3) @(posedge clk) #1;
    chk("float all", 32'h2, {28'h0, doe, aoe, rwoe, soe});
    fam = 1'b0;
    rel_n = 1'b0;
    for (int n = 0; n < 12 && ack_n !== 1'b0; n++) @(posedge clk) #1;
    chk("hold ack", 32'h0, {31'h0, ack_n});
    chk("hold oe", 32'h0, {27'h0, rreq, doe, aoe, rwoe, soe});
    rel_n = 1'b1;
    repeat (6) @(posedge clk) #1;
    chk("ack back", 32'h3, {30'h0, ack_n, rreq});
    inh = 1'b1;
    rel_n = 1'b0;
    repeat (8) @(posedge clk) #1;
    chk("inhibit", 32'h1, {31'h0, ack_n});
    acc(1, 0, 0, 26'h000008, 4'hf, 32'h55);
    chk("inh drives", 32'h2, c_addr);
    // drop the request first so the inhibit never uncovers a stale one
    rel_n = 1'b1;
    repeat (3) @(posedge clk) #1;
    inh = 1'b0;
    $display("test release done");
  endtask
  task automatic t_split;
    acc(1, 0, 0, 26'h000010, 4'h7, 32'h1111beef);
    chk("b0 lane3 off", 32'h8, c_b0);
    {w0, pw, fch} = {WIDTH_16, 2'b11};
    repeat (3) @(posedge clk) #1;
    acc(0, 0, 0, 26'h000010, 4'hf, 32'h0);
    chk("split first half", 32'h0, {31'h0, c_b0[3]});
    chk("split second half", 32'h1, {31'h0, c_lst[3]});
    chk("split data", 32'hbeef1234, rdata);
    {w0, pw, fch} = {WIDTH_32, 2'b00};
    $display("test split fetch done");
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // limit well above the roughly 140 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk) #1;
    t_reset();
    repeat (3) @(posedge clk) #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk) #1;
    t_wr_rd();
    t_lanes();
    t_io_wait();
    t_release();
    t_split();
    conclude();
  end
endmodule
`default_nettype wire
